// ### rtl/idm_pkg.sv
// Operation
// [RULE1] The data memory holds 256 bytes, and in the upper half the addressing form picks the target.
// [RULE2] An indirect access to an upper-half address goes to general-purpose RAM.
// [RULE3] A direct access to an upper-half address goes to the special function space, not RAM.
// [RULE4] Lower-half addresses always reach RAM, the same bytes for direct and indirect forms.
// [RULE5] The lowest 32 RAM bytes also form four working register banks of eight bytes each.
// [RULE6] The 16 bytes after the banks are reachable as whole bytes and as single bits.
// [RULE7] Bit addresses 0x00 to 0x7F map upward over those 16 bytes, least significant bit first.
package idm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam int BANK_BYTES = 8;
  localparam int BANKS = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_INDIRECT = 2'b01,
    MODE_BANK_REG = 2'b10,
    MODE_BIT = 2'b11
  } idm_mode_t;
endpackage : idm_pkg

// ### rtl/idm_ram.sv
`timescale 1ns/10ps
`default_nettype none
module idm_ram #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign rd_data = mem_q[rd_idx];
endmodule : idm_ram
`default_nettype wire

// ### rtl/idm_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module idm_decoder (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire idm_pkg::idm_mode_t acc_mode,
  input wire logic [7:0] acc_addr,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata_q,
  output logic acc_rvalid_q,
  output logic sfs_valid,
  output logic sfs_write,
  output logic [6:0] sfs_addr,
  output logic [7:0] sfs_wdata,
  input wire logic [7:0] sfs_rdata
);
  import idm_pkg::*;

  // Where a latched read takes its byte from
  typedef enum logic [1:0] {
    SRC_RAM_BYTE = 2'b00,
    SRC_RAM_BIT = 2'b01,
    SRC_SFS = 2'b10,
    SRC_HOLD = 2'b11
  } idm_src_t;

  logic rst_meta_d;
  logic rst_meta_q;
  logic rst_sync_d;
  logic rst_sync_q;

  always_comb begin
    rst_meta_d = 1'b1;
    rst_sync_d = rst_meta_q;
  end

  // Assertion is asynchronous, release waits two edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
    end
  end

  logic addr_upper;
  logic [ADDR_W-1:0] byte_idx;
  logic [ADDR_W-1:0] bank_base;
  logic [ADDR_W-1:0] bank_idx;
  logic [ADDR_W-1:0] bit_byte_idx;
  logic [2:0] bit_pos;

  // Upper half is the only place where the two spaces overlap
  assign addr_upper = (acc_addr >= UPPER_BASE);

  // Two select bits keep all four banks inside the lowest 32 bytes
  always_comb begin
    byte_idx = acc_addr; // RULE4
    bank_base = ADDR_W'(bank_sel) * ADDR_W'(BANK_BYTES); // RULE5
    bank_idx = bank_base + {5'h0, acc_addr[2:0]}; // RULE5
  end

  // Top address bit is ignored, so bit addresses wrap at 0x80
  always_comb begin
    bit_byte_idx = BIT_BASE + {4'h0, acc_addr[6:3]}; // RULE7
    bit_pos = acc_addr[2:0]; // RULE7
  end

  logic to_sfs;
  logic [ADDR_W-1:0] ram_idx;
  idm_src_t rd_src;

  // Addressing form picks the target; only direct upper leaves RAM
  always_comb begin
    to_sfs = 1'b0;
    ram_idx = byte_idx;
    case (acc_mode)
      MODE_DIRECT: begin
        to_sfs = addr_upper; // RULE3
        ram_idx = byte_idx; // RULE4
      end
      MODE_INDIRECT: begin
        // Indirect form never leaves RAM, upper half included
        ram_idx = byte_idx; // RULE2
      end
      MODE_BANK_REG: begin
        ram_idx = bank_idx; // RULE5
      end
      MODE_BIT: begin
        ram_idx = bit_byte_idx; // RULE7
      end
      default: begin
        to_sfs = 1'b0;
        ram_idx = byte_idx;
      end
    endcase
  end

  // Read source follows the same split as the routing above
  always_comb begin
    rd_src = SRC_RAM_BYTE;
    case (acc_mode)
      MODE_DIRECT: begin
        if (addr_upper) begin
          rd_src = SRC_SFS; // RULE3
        end
      end
      MODE_INDIRECT: begin
        rd_src = SRC_RAM_BYTE; // RULE2
      end
      MODE_BANK_REG: begin
        rd_src = SRC_RAM_BYTE; // RULE5
      end
      MODE_BIT: begin
        rd_src = SRC_RAM_BIT; // RULE6
      end
      default: begin
        rd_src = SRC_HOLD;
      end
    endcase
  end

  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] bit_fill;
  logic [DATA_W-1:0] bit_merged;
  logic ram_we;
  logic [DATA_W-1:0] ram_wdata;

  // Only the addressed bit changes, its neighbours come back from the array
  always_comb begin
    bit_mask = {{(DATA_W - 1){1'b0}}, 1'b1} << bit_pos; // RULE7
    bit_fill = {DATA_W{acc_wdata[0]}};
    bit_merged = (ram_rdata & ~bit_mask) | (bit_fill & bit_mask); // RULE6
  end

  // Bit writes are read-modify-write in one cycle on the flop array
  always_comb begin
    ram_we = acc_valid && acc_write && !to_sfs; // RULE1
    ram_wdata = acc_wdata;
    if (acc_mode == MODE_BIT) begin
      ram_wdata = bit_merged; // RULE6
    end
  end

  // Fields idle at zero unless direct mode has an upper address, valid or not, less toggling far side
  always_comb begin
    sfs_valid = acc_valid && to_sfs; // RULE3
    sfs_write = 1'b0;
    sfs_addr = 7'h00;
    sfs_wdata = 8'h00;
    if (to_sfs) begin
      sfs_write = acc_write; // RULE3
      sfs_addr = acc_addr[6:0]; // RULE3
      sfs_wdata = acc_wdata; // RULE3
    end
  end

  idm_ram #(
    .DEPTH(RAM_BYTES),
    .WIDTH(DATA_W)
  ) u_ram (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_q),
    .wr_en(ram_we),
    .wr_idx(ram_idx),
    .wr_data(ram_wdata),
    .rd_idx(ram_idx),
    .rd_data(ram_rdata)
  );

  logic rd_req;
  logic [DATA_W-1:0] bit_value;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_d;

  assign rd_req = acc_valid && !acc_write;

  // Bit reads come back in bit 0, the rest reads as zero
  assign bit_value = {{(DATA_W - 1){1'b0}}, ram_rdata[bit_pos]}; // RULE6

  always_comb begin
    rvalid_d = rd_req; // RULE1
  end

  // Read valid is a single-cycle pulse per accepted read
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      acc_rvalid_q <= 1'b0;
    end else begin
      acc_rvalid_q <= rvalid_d;
    end
  end

  // Read data registered so RAM and special space answer alike
  // A byte written in the same cycle reads back its old contents
  always_comb begin
    rdata_d = acc_rdata_q;
    if (rd_req) begin
      case (rd_src)
        SRC_SFS: begin
          rdata_d = sfs_rdata; // RULE3
        end
        SRC_RAM_BIT: begin
          rdata_d = bit_value; // RULE6
        end
        SRC_RAM_BYTE: begin
          rdata_d = ram_rdata; // RULE4
        end
        default: begin
          rdata_d = acc_rdata_q;
        end
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      acc_rdata_q <= RESET_BYTE;
    end else begin
      acc_rdata_q <= rdata_d;
    end
  end
endmodule : idm_decoder
`default_nettype wire

// ### sim/idm_checker.sv
`timescale 1ns/10ps
`default_nettype none
module idm_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire idm_pkg::idm_mode_t acc_mode,
  input wire logic [7:0] acc_addr,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata_q,
  input wire logic acc_rvalid_q,
  input wire logic sfs_valid,
  input wire logic sfs_write,
  input wire logic [6:0] sfs_addr,
  input wire logic [7:0] sfs_wdata,
  input wire logic [7:0] sfs_rdata
);
  import idm_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire up_dir = acc_valid && acc_mode == MODE_DIRECT && acc_addr[7];
  chk_sfs_select: assert property (sfs_valid == up_dir)
    else $error("sfs select");
  chk_sfs_fields: assert property (sfs_valid |-> sfs_addr == acc_addr[6:0]
    && sfs_write == acc_write && sfs_wdata == acc_wdata) else $error("sfs fields");
  chk_sfs_rdata: assert property (up_dir && !acc_write |=>
    acc_rdata_q == $past(sfs_rdata)) else $error("sfs rdata");
  chk_read_pulse: assert property (acc_rvalid_q == $past(acc_valid && !acc_write))
    else $error("rvalid");
  chk_rdata_hold: assert property (!acc_rvalid_q |-> $stable(acc_rdata_q))
    else $error("rdata hold");
  chk_bit_rdata: assert property (acc_valid && acc_mode == MODE_BIT && !acc_write |=>
    acc_rdata_q[7:1] == 7'h00) else $error("bit rdata");
  cover property (up_dir && !acc_write);
  cover property (acc_valid && acc_write && acc_mode == MODE_BIT);
  cover property (acc_valid && acc_mode == MODE_BIT);
  cover property (acc_valid && acc_mode == MODE_BANK_REG);
endmodule : idm_checker
bind idm_decoder idm_checker u_chk (.*);
`default_nettype wire

// ### sim/idm_sfs_model.sv
`timescale 1ns/10ps
`default_nettype none
module idm_sfs_model (
  input wire logic ref_clk,
  input wire logic sfs_valid,
  input wire logic sfs_write,
  input wire logic [6:0] sfs_addr,
  input wire logic [7:0] sfs_wdata,
  output logic [7:0] sfs_rdata
);
  logic [7:0] store_q [128];
  logic [7:0] junk_q = 8'h00;
  // Moving junk when unselected, so a stale value never passes
  always @(posedge ref_clk) begin
    junk_q <= junk_q + 8'h01;
    if (sfs_valid && sfs_write) store_q[sfs_addr] <= sfs_wdata;
  end
  assign sfs_rdata = sfs_valid ? store_q[sfs_addr] : junk_q;
endmodule : idm_sfs_model
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import idm_pkg::*;
  logic ref_clk = 0, rstn = 0, acc_valid = 0, acc_write = 0, acc_rvalid_q, sfs_valid, sfs_write;
  idm_mode_t acc_mode = MODE_DIRECT;
  logic [7:0] acc_addr = '0, acc_wdata = '0, acc_rdata_q, sfs_wdata, sfs_rdata;
  logic [1:0] bank_sel = '0;
  logic [6:0] sfs_addr;
  int bad_count = 0, tests_run = 0;
  idm_decoder dut (.*);
  idm_sfs_model sfs (.*);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  // Every access checks the read pulse; reads also check the data against d
  task automatic acc(input logic wr, input idm_mode_t m, input logic [7:0] a, d,
                     input logic [1:0] b = 2'h0);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_mode <= m;
    acc_addr <= a;
    acc_wdata <= d;
    bank_sel <= b;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    #1;
    check("acc_rvalid_q", {7'h00, acc_rvalid_q}, {7'h00, ~wr});
    if (!wr) check("acc_rdata_q", acc_rdata_q, d);
  endtask : acc
  task automatic t_upper;
    acc(1, MODE_INDIRECT, 8'h90, 8'hA5);
    acc(1, MODE_DIRECT, 8'h90, 8'h3C);
    acc(0, MODE_INDIRECT, 8'h90, 8'hA5);
    acc(0, MODE_DIRECT, 8'h90, 8'h3C);
    acc(1, MODE_INDIRECT, 8'hFF, 8'h5C);
    acc(0, MODE_INDIRECT, 8'hFF, 8'h5C);
  endtask : t_upper
  task automatic t_lower_bank;
    acc(1, MODE_DIRECT, 8'h40, 8'h66);
    acc(0, MODE_INDIRECT, 8'h40, 8'h66);
    acc(1, MODE_BANK_REG, 8'h05, 8'h77, 2'h2);
    acc(0, MODE_DIRECT, 8'h15, 8'h77);
    acc(1, MODE_BANK_REG, 8'h07, 8'h11, 2'h3);
    acc(0, MODE_INDIRECT, 8'h1F, 8'h11);
  endtask : t_lower_bank
  task automatic t_bits;
    acc(1, MODE_BIT, 8'h0B, 8'h01);
    acc(0, MODE_DIRECT, 8'h21, 8'h08);
    acc(0, MODE_BIT, 8'h0B, 8'h01);
    acc(1, MODE_BIT, 8'h7F, 8'h01);
    acc(0, MODE_DIRECT, 8'h2F, 8'h80);
    acc(1, MODE_DIRECT, 8'h21, 8'hFF);
    acc(1, MODE_BIT, 8'h0B, 8'hFE);
    acc(0, MODE_DIRECT, 8'h21, 8'hF7);
    acc(0, MODE_BIT, 8'h0B, 8'h00);
  endtask : t_bits
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_upper();
    t_lower_bank();
    t_bits();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
